// ### shs_defs.svh
`ifndef SHS_DEFS_SVH
`define SHS_DEFS_SVH

// Register offsets (byte addresses, one word each)
`define SHS_A_DATA 8'h00
`define SHS_A_TASK 8'h04
`define SHS_A_CMD 8'h08
`define SHS_A_STATUS 8'h0C
`define SHS_A_CONTROL 8'h10
`define SHS_A_DMA_CTRL 8'h14
`define SHS_A_DMA_COUNT 8'h18
`define SHS_A_INFO 8'h1C

// Shadow status bit positions
`define SHS_ST_BUSY 7
`define SHS_ST_SERVICE_REQUEST_FLAG 4
`define SHS_ST_DRQ 3
`define SHS_ST_REL 2

// Status reset value and DMA control ready bit position
`define SHS_ST_RESET 8'h00
`define SHS_DMA_CTRL_READY 0

// Sizes and counts
`define SHS_FIFO_DEPTH 16
`define SHS_FRAME_WORDS 16'h0800

`endif

// ### shs_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module shs_drive_model (
	// Clock
	input wire logic pclk,
	// Frames and words toward the adapter
	output logic rx_hdr_valid,
	output shs_pkg::shs_fis_hdr_t rx_hdr,
	output logic rx_valid,
	output logic [31:0] rx_data,
	input wire logic rx_ready,
	// Words from the adapter
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [31:0] txq[$];
	logic lastq[$];
	logic [1:0] ph;
	initial begin
		rx_hdr_valid = 1'b0;
		rx_hdr = '0;
		rx_valid = 1'b0;
		rx_data = 32'hFFFFFFFF;
		tx_ready = 1'b0;
		ph = 2'h0;
	end
	// Stall one cycle in four so the outbound side really sees back-pressure
	always @(posedge pclk) begin
		ph <= ph + 2'h1;
		tx_ready <= (ph != 2'h3);
		if (tx_valid && tx_ready) begin
			txq.push_back(tx_data);
			lastq.push_back(tx_last);
		end
	end
	task automatic hdr(input shs_pkg::shs_fis_kind_t k, input logic f, input logic d,
		input logic [7:0] s, input logic [7:0] e, input logic [15:0] n, input logic [31:0] t);
		rx_hdr_valid <= 1'b1;
		rx_hdr <= '{k, f, d, s, e, n, t};
		@(posedge pclk);
		rx_hdr_valid <= 1'b0;
		// Released header lines do not keep the old value
		rx_hdr <= shs_pkg::shs_fis_hdr_t'(~{k, f, d, s, e, n, t});
	endtask
	// Data frame words follow a header, paced by rx_ready
	task automatic words(input int n, input logic [31:0] base);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= base + i;
			do @(posedge pclk); while (!rx_ready);
		end
		rx_valid <= 1'b0;
		rx_data <= ~(base + n - 1);
	endtask
endmodule // shs_drive_model
`default_nettype wire

// ### shs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module shs_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	logic [AW:0] next_wptr;
	logic [AW:0] next_rptr;

	// Extra pointer bit tells full from empty; DEPTH must be a power of two
	assign in_ready = (wptr - rptr) != (AW + 1)'(DEPTH);
	assign out_valid = wptr != rptr;
	assign out_data = mem[rptr[AW-1:0]];

	always_comb begin
		next_wptr = wptr;
		next_rptr = rptr;
		if (in_valid && in_ready) begin
			next_wptr = wptr + (AW + 1)'(1);
		end
		if (out_valid && out_ready) begin
			next_rptr = rptr + (AW + 1)'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end

	always_ff @(posedge pclk) begin
		if (in_valid && in_ready) begin
			mem[wptr[AW-1:0]] <= in_data;
		end
	end
endmodule // shs_fifo
`default_nettype wire

// ### shs_host_adapter.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.svh"
module shs_host_adapter (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt to host
	output logic irq,
	// Inbound frame headers from link
	input wire logic rx_hdr_valid,
	input wire shs_pkg::shs_fis_hdr_t rx_hdr,
	// Inbound data words from link
	input wire logic rx_valid,
	input wire logic [31:0] rx_data,
	output logic rx_ready,
	// Outbound register frame to link
	output logic txr_valid,
	output shs_pkg::shs_h2d_t txr,
	// Outbound data words to link
	output logic tx_valid,
	output logic [31:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// DMA controller, read data toward memory
	output logic dma_rd_valid,
	output logic [31:0] dma_rd_data,
	input wire logic dma_rd_ready,
	// DMA controller, write data from memory
	input wire logic dma_wr_valid,
	input wire logic [31:0] dma_wr_data,
	output logic dma_wr_ready
);
	shs_pkg::shs_ctl_t c;
	shs_pkg::shs_ctl_t next_c;
	shs_pkg::shs_rd_t rd;
	shs_pkg::shs_rd_t next_rd;

	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic rxf_in_ready;
	logic rxf_out_valid;
	logic rxf_out_ready;
	logic [31:0] rxf_out_data;
	logic rx_push;
	logic txf_in_valid;
	logic txf_in_ready;
	logic [32:0] txf_in_data;
	logic [32:0] txf_out_data;
	logic pio_wr;
	logic pio_rd;
	logic pio_last;
	logic dma_push;
	logic dma_last;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign mapped = hit(paddr, `SHS_A_DATA) || hit(paddr, `SHS_A_TASK) ||
		hit(paddr, `SHS_A_CMD) || hit(paddr, `SHS_A_STATUS) ||
		hit(paddr, `SHS_A_CONTROL) || hit(paddr, `SHS_A_DMA_CTRL) ||
		hit(paddr, `SHS_A_DMA_COUNT) || hit(paddr, `SHS_A_INFO);

	// Data port stalls instead of underflowing or overflowing a FIFO
	always_comb begin
		pready = penable;
		if (hit(paddr, `SHS_A_DATA)) begin
			if (!pwrite && c.mode == shs_pkg::SHS_PIO_IN && !rd.have) begin
				pready = 1'b0;
			end
			if (pwrite && c.mode == shs_pkg::SHS_PIO_OUT && !txf_in_ready) begin
				pready = 1'b0;
			end
		end
	end

	assign pslverr = psel && penable && !mapped;
	assign acc = psel && penable && pready;
	assign wr_acc = acc && pwrite && mapped;
	assign rd_acc = acc && !pwrite && mapped;
	assign prdata = rd.data;

	assign pio_rd = rd_acc && hit(paddr, `SHS_A_DATA) && c.mode == shs_pkg::SHS_PIO_IN;
	assign pio_wr = wr_acc && hit(paddr, `SHS_A_DATA) && c.mode == shs_pkg::SHS_PIO_OUT;
	assign pio_last = pio_wr && (c.cnt + 16'h0001) == c.tgt;

	// Read data is registered a cycle ahead, so a read sees state one cycle old
	always_comb begin
		next_rd = rd;
		if (psel) begin
			next_rd.have = rxf_out_valid;
			case (paddr)
				`SHS_A_DATA: next_rd.data = (c.mode == shs_pkg::SHS_PIO_IN) ? rxf_out_data : '0;
				`SHS_A_TASK: next_rd.data = c.task_word;
				`SHS_A_CMD: next_rd.data = {24'h000000, c.txr.command};
				`SHS_A_STATUS: next_rd.data = {24'h000000, c.status};
				`SHS_A_CONTROL: next_rd.data = {24'h000000, c.control};
				`SHS_A_DMA_CTRL: next_rd.data = {31'h00000000, c.dma_ready};
				`SHS_A_DMA_COUNT: next_rd.data = {16'h0000, c.remain};
				`SHS_A_INFO: next_rd.data = {16'h0000, c.cnt[7:0], 3'h0, c.mode,
					c.dma_tx, c.act_pending, c.hold_valid};
				default: next_rd.data = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd <= '0;
		end else begin
			rd <= next_rd;
		end
	end

	// Inbound FIFO serves both PIO reads and the DMA path
	assign rx_ready = rxf_in_ready && ((c.mode == shs_pkg::SHS_PIO_IN && c.cnt != c.tgt) ||
		c.mode == shs_pkg::SHS_DMA_IN);
	assign rx_push = rx_valid && rx_ready;
	assign dma_rd_valid = rxf_out_valid && c.mode == shs_pkg::SHS_DMA_IN && c.dma_ready;
	assign dma_rd_data = rxf_out_data;
	assign rxf_out_ready = pio_rd || (dma_rd_valid && dma_rd_ready);

	shs_fifo #(.WIDTH(32), .DEPTH(`SHS_FIFO_DEPTH)) u_rx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(rx_push),
		.in_ready(rxf_in_ready),
		.in_data(rx_data),
		.out_valid(rxf_out_valid),
		.out_ready(rxf_out_ready),
		.out_data(rxf_out_data)
	);

	// Outbound FIFO carries the end-of-frame mark beside each word
	assign dma_wr_ready = c.dma_tx && txf_in_ready && c.mode != shs_pkg::SHS_PIO_OUT;
	assign dma_push = dma_wr_valid && dma_wr_ready;
	assign dma_last = c.remain == 16'h0001 || (c.fcnt + 16'h0001) == `SHS_FRAME_WORDS;
	assign txf_in_valid = pio_wr || dma_push;
	assign txf_in_data = pio_wr ? {pio_last, pwdata} : {dma_last, dma_wr_data};
	assign tx_last = txf_out_data[32];
	assign tx_data = txf_out_data[31:0];

	shs_fifo #(.WIDTH(33), .DEPTH(`SHS_FIFO_DEPTH)) u_tx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(txf_in_valid),
		.in_ready(txf_in_ready),
		.in_data(txf_in_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(txf_out_data)
	);

	assign irq = c.irq;
	assign txr_valid = c.txr_valid;
	assign txr = c.txr;

	always_comb begin
		next_c = c;
		next_c.txr_valid = 1'b0;
		// Status read clears first so a same-cycle event still sets it
		if (rd_acc && hit(paddr, `SHS_A_STATUS)) begin
			next_c.irq = 1'b0;
		end
		if (wr_acc) begin
			case (paddr)
				`SHS_A_TASK: next_c.task_word = pwdata;
				`SHS_A_CONTROL: next_c.control = pwdata[7:0];
				`SHS_A_DMA_CTRL: next_c.dma_ready = pwdata[`SHS_DMA_CTRL_READY];
				`SHS_A_DMA_COUNT: next_c.remain = pwdata[15:0];
				`SHS_A_CMD: begin
					next_c.status[`SHS_ST_BUSY] = 1'b1;
					next_c.txr = '{task_word: c.task_word, command: pwdata[7:0],
						control: c.control};
					next_c.txr_valid = 1'b1;
				end
				default: ;
			endcase
		end
		if (pio_wr) begin
			next_c.cnt = c.cnt + 16'h0001;
			if (pio_last) begin
				next_c.status = c.est;
				next_c.status[`SHS_ST_DRQ] = 1'b0;
				next_c.status[`SHS_ST_BUSY] = 1'b1;
				next_c.mode = shs_pkg::SHS_IDLE;
			end
		end
		if (rx_push && c.mode == shs_pkg::SHS_PIO_IN) begin
			next_c.cnt = c.cnt + 16'h0001;
		end
		if (c.mode == shs_pkg::SHS_PIO_IN && c.cnt == c.tgt && !rxf_out_valid) begin
			next_c.status = c.est;
			next_c.status[`SHS_ST_DRQ] = 1'b0;
			next_c.status[`SHS_ST_BUSY] = 1'b1;
			next_c.mode = shs_pkg::SHS_IDLE;
		end
		// An early activation waits here for software to restore the context
		if (c.act_pending && c.dma_ready && !c.dma_tx && c.remain != 16'h0000) begin
			next_c.dma_tx = 1'b1;
			next_c.act_pending = 1'b0;
			next_c.fcnt = '0;
		end
		if (dma_push) begin
			next_c.remain = c.remain - 16'h0001;
			next_c.fcnt = c.fcnt + 16'h0001;
			if (dma_last) begin
				next_c.dma_tx = 1'b0;
			end
		end
		// Link events last: a frame overrides a same-cycle software change
		if (rx_hdr_valid) begin
			case (rx_hdr.kind)
				shs_pkg::SHS_FR_REG_D2H: begin
					next_c.status = rx_hdr.status;
					if (rx_hdr.status[`SHS_ST_REL]) begin
						next_c.status[`SHS_ST_BUSY] = 1'b0;
					end
					next_c.task_word = rx_hdr.task_word;
					if (rx_hdr.irq_flag) begin
						next_c.irq = 1'b1;
					end
					if (c.mode == shs_pkg::SHS_DMA_IN) begin
						next_c.mode = shs_pkg::SHS_IDLE;
					end
				end
				shs_pkg::SHS_FR_SDB: begin
					next_c.status[`SHS_ST_SERVICE_REQUEST_FLAG] = 1'b1;
					if (!c.status[`SHS_ST_BUSY]) begin
						next_c.irq = 1'b1;
					end
				end
				shs_pkg::SHS_FR_DMA_ACT: begin
					next_c.act_pending = 1'b1;
				end
				shs_pkg::SHS_FR_PIO_SETUP: begin
					if (rx_hdr.dir_d2h) begin
						next_c.hold_valid = 1'b1;
						next_c.hold = rx_hdr;
					end else begin
						next_c.status = rx_hdr.status;
						next_c.status[`SHS_ST_BUSY] = 1'b0;
						next_c.status[`SHS_ST_DRQ] = 1'b1;
						next_c.tgt = rx_hdr.count;
						next_c.est = rx_hdr.e_status;
						next_c.cnt = '0;
						next_c.mode = shs_pkg::SHS_PIO_OUT;
						next_c.irq = next_c.irq || rx_hdr.irq_flag;
					end
				end
				shs_pkg::SHS_FR_DATA: begin
					if (c.hold_valid) begin
						next_c.task_word = c.hold.task_word;
						next_c.status = c.hold.status;
						next_c.status[`SHS_ST_BUSY] = 1'b0;
						next_c.status[`SHS_ST_DRQ] = 1'b1;
						next_c.tgt = c.hold.count;
						next_c.est = c.hold.e_status;
						next_c.cnt = '0;
						next_c.mode = shs_pkg::SHS_PIO_IN;
						next_c.hold_valid = 1'b0;
						next_c.irq = next_c.irq || c.hold.irq_flag;
					end else if (c.mode == shs_pkg::SHS_IDLE) begin
						next_c.mode = shs_pkg::SHS_DMA_IN;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c <= '0;
			c.status <= `SHS_ST_RESET;
		end else begin
			c <= next_c;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_cmd_busy: assert property (
		wr_acc && hit(paddr, `SHS_A_CMD) && !rx_hdr_valid
		|=> c.status[`SHS_ST_BUSY] && txr_valid && txr.command == $past(pwdata[7:0]))
		else $error("command write did not set busy and send frame");

	chk_release_flag: assert property (
		rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_REG_D2H && rx_hdr.status[`SHS_ST_REL]
		|=> !c.status[`SHS_ST_BUSY] && c.status[`SHS_ST_REL])
		else $error("release frame left busy set");

	chk_service_irq: assert property (
		rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_SDB && !c.status[`SHS_ST_BUSY]
		|=> c.status[`SHS_ST_SERVICE_REQUEST_FLAG] && irq)
		else $error("service request lost");

	chk_fifo_throttle: assert property (
		rx_push && c.mode == shs_pkg::SHS_DMA_IN && !c.dma_ready && !wr_acc
		|=> rxf_out_valid && !dma_rd_valid)
		else $error("early read data was not held in the FIFO");

	chk_end_irq: assert property (
		rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_REG_D2H && rx_hdr.irq_flag
		|=> irq [*1] ##0 c.task_word == $past(rx_hdr.task_word))
		else $error("ending frame did not raise interrupt");

	chk_dma_count: assert property (
		dma_push |-> c.remain != 16'h0000 ##1 c.remain == $past(c.remain) - 16'h0001)
		else $error("DMA write exceeded programmed count");

	chk_act_pending: assert property (
		rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_DMA_ACT && !c.dma_ready && !c.dma_tx
		|=> c.act_pending ##1 (c.act_pending || c.dma_tx))
		else $error("early activation was dropped");

	chk_pio_out_drq: assert property (
		rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_PIO_SETUP && !rx_hdr.dir_d2h
		|=> c.status[`SHS_ST_DRQ] && !c.status[`SHS_ST_BUSY] && c.mode == shs_pkg::SHS_PIO_OUT)
		else $error("outbound setup did not open data phase");

	chk_final_status: assert property (
		pio_last && !rx_hdr_valid
		|=> c.status[`SHS_ST_BUSY] && !c.status[`SHS_ST_DRQ] ##0 tx_valid)
		else $error("last written word did not close the phase");

	chk_hold_quiet: assert property (
		rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_PIO_SETUP && rx_hdr.dir_d2h && !wr_acc
		|=> $stable(c.status) && $stable(c.task_word) && c.hold_valid)
		else $error("held setup touched the shadows");

	chk_pio_in_end: assert property (
		c.mode == shs_pkg::SHS_PIO_IN && c.cnt == c.tgt && !rxf_out_valid && !rx_hdr_valid
		|=> !c.status[`SHS_ST_DRQ] && c.status[`SHS_ST_BUSY] && c.mode == shs_pkg::SHS_IDLE)
		else $error("inbound phase did not end");

	chk_irq_clear: assert property (
		rd_acc && hit(paddr, `SHS_A_STATUS) && !rx_hdr_valid |=> !irq)
		else $error("status read left interrupt set");

	cov_pio_in: cover property (c.mode == shs_pkg::SHS_PIO_IN ##[1:200] c.mode == shs_pkg::SHS_IDLE);
	cov_dma_write: cover property (dma_push && dma_last);
	cov_dma_read: cover property (dma_rd_valid && dma_rd_ready);
	cov_service: cover property (rx_hdr_valid && rx_hdr.kind == shs_pkg::SHS_FR_SDB ##1 irq);
endmodule // shs_host_adapter
`default_nettype wire

// ### shs_pkg.sv
package shs_pkg;

	typedef enum logic [2:0] {
		SHS_FR_REG_D2H,
		SHS_FR_SDB,
		SHS_FR_DMA_ACT,
		SHS_FR_PIO_SETUP,
		SHS_FR_DATA
	} shs_fis_kind_t;

	typedef enum logic [1:0] {
		SHS_IDLE,
		SHS_PIO_OUT,
		SHS_PIO_IN,
		SHS_DMA_IN
	} shs_mode_t;

	typedef struct packed {
		shs_fis_kind_t kind;
		logic irq_flag;
		logic dir_d2h;
		logic [7:0] status;
		logic [7:0] e_status;
		logic [15:0] count;
		logic [31:0] task_word;
	} shs_fis_hdr_t;

	typedef struct packed {
		logic [31:0] task_word;
		logic [7:0] command;
		logic [7:0] control;
	} shs_h2d_t;

	typedef struct packed {
		logic [7:0] status;
		logic [31:0] task_word;
		logic [7:0] control;
		logic irq;
		shs_mode_t mode;
		logic hold_valid;
		shs_fis_hdr_t hold;
		logic [15:0] tgt;
		logic [7:0] est;
		logic [15:0] cnt;
		logic act_pending;
		logic dma_ready;
		logic [15:0] remain;
		logic [15:0] fcnt;
		logic dma_tx;
		logic txr_valid;
		shs_h2d_t txr;
	} shs_ctl_t;

	typedef struct packed {
		logic [31:0] data;
		logic have;
	} shs_rd_t;

endpackage

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, v, tw;
	logic rx_hdr_valid, rx_valid, rx_ready, txr_valid, tx_valid, tx_last, tx_ready;
	shs_pkg::shs_fis_hdr_t rx_hdr;
	shs_pkg::shs_h2d_t txr, txr_seen;
	logic [31:0] rx_data, tx_data, dma_rd_data, dma_wr_data;
	logic dma_rd_valid, dma_rd_ready, dma_wr_valid, dma_wr_ready;
	logic [15:0] lf;
	logic [31:0] rq[$];
	logic [31:0] eq[$];
	int err_count, n_compared, cyc, ntxr;
	shs_host_adapter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .txr_valid(txr_valid),
		.txr(txr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .dma_rd_valid(dma_rd_valid), .dma_rd_data(dma_rd_data),
		.dma_rd_ready(dma_rd_ready), .dma_wr_valid(dma_wr_valid), .dma_wr_data(dma_wr_data),
		.dma_wr_ready(dma_wr_ready));
	shs_drive_model dm (.pclk(pclk), .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (txr_valid) begin
			ntxr <= ntxr + 1;
			txr_seen <= txr;
		end
		if (dma_rd_valid && dma_rd_ready) rq.push_back(dma_rd_data);
		if (cyc == 5000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end
	function automatic logic [31:0] rnd_word(input logic [15:0] s);
		return {s, ~s};
	endfunction
	// Ending status: busy forced on, data request forced off
	function automatic logic [31:0] end_st(input logic [7:0] e);
		return {24'h0, 1'b1, e[6:4], 1'b0, e[2:0]};
	endfunction
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic nr();
		lf = lfsr_next(lf);
		v = rnd_word(lf);
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next call never reassigns psel in this step
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, r, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; i < 300 && dm.txq.size() < n; i++) @(posedge pclk);
	endtask
	task automatic stop_test();
		if (err_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, dma_rd_ready, dma_wr_valid} = '0;
		dma_wr_data = 32'hFFFFFFFF;
		{err_count, n_compared, cyc, ntxr} = '0;
		lf = 16'h8DBE;
		presetn = 1'b0;
		tick(6);
		presetn <= 1'b1;
		tick(1);
		rd(`SHS_A_STATUS, 32'h0, "status after reset");
		nr();
		tw = v;
		apb(1'b1, `SHS_A_TASK, tw);
		apb(1'b1, `SHS_A_CONTROL, {24'h0, tw[15:8]});
		apb(1'b1, `SHS_A_CMD, 32'h000000C7);
		tick(2);
		check("cmd frames", ntxr, 1);
		check("frame task", txr_seen.task_word, tw);
		check("frame cmd", {24'h0, txr_seen.command}, 32'hC7);
		check("frame ctl", {24'h0, txr_seen.control}, {24'h0, tw[15:8]});
		rd(`SHS_A_STATUS, 32'h80, "status busy");
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped error", {31'h0, last_err}, 32'h1);
		dm.hdr(shs_pkg::SHS_FR_SDB, 1'b1, 1'b1, 8'h00, 8'h00, 16'h0, 32'h0);
		tick(2);
		check("no irq while busy", {31'h0, irq}, 32'h0);
		dm.hdr(shs_pkg::SHS_FR_REG_D2H, 1'b0, 1'b1, 8'h04, 8'h00, 16'h0, tw);
		tick(1);
		rd(`SHS_A_STATUS, 32'h04, "status released");
		dm.hdr(shs_pkg::SHS_FR_SDB, 1'b1, 1'b1, 8'h00, 8'h00, 16'h0, 32'h0);
		tick(2);
		check("service irq", {31'h0, irq}, 32'h1);
		apb(1'b0, `SHS_A_STATUS, 32'h0);
		check("service flag", {31'h0, r[4]}, 32'h1);
		tick(1);
		check("irq cleared by read", {31'h0, irq}, 32'h0);
		// Outbound packet: three words, last one closes the frame
		apb(1'b1, `SHS_A_CMD, 32'h000000A0);
		dm.hdr(shs_pkg::SHS_FR_PIO_SETUP, 1'b0, 1'b0, 8'h08, 8'h80, 16'h3, tw);
		tick(1);
		rd(`SHS_A_STATUS, 32'h08, "setup status out");
		for (int i = 0; i < 3; i++) begin
			nr();
			eq.push_back(v);
			apb(1'b1, `SHS_A_DATA, v);
		end
		wait_q(3);
		for (int i = 0; i < 3; i++) begin
			check("out word", dm.txq[i], eq[i]);
			check("out last", {31'h0, dm.lastq[i]}, (i == 2) ? 32'h1 : 32'h0);
		end
		rd(`SHS_A_STATUS, 32'h80, "final status out");
		// Inbound packet data: setup is held until the data frame
		dm.hdr(shs_pkg::SHS_FR_PIO_SETUP, 1'b1, 1'b1, 8'h09, 8'h01, 16'h4, tw);
		tick(3);
		rd(`SHS_A_STATUS, 32'h80, "setup held");
		dm.hdr(shs_pkg::SHS_FR_DATA, 1'b0, 1'b1, 8'h00, 8'h00, 16'h0, 32'h0);
		tick(1);
		check("data-in irq", {31'h0, irq}, 32'h1);
		rd(`SHS_A_STATUS, 32'h09, "initial status in");
		nr();
		fork
			dm.words(4, v);
		join_none
		for (int i = 0; i < 4; i++) rd(`SHS_A_DATA, v + i, "in word");
		tick(3);
		rd(`SHS_A_STATUS, end_st(8'h01), "ending status in");
		// Queued write: activation arrives before the context is restored
		dm.txq.delete();
		dm.lastq.delete();
		apb(1'b1, `SHS_A_DMA_CTRL, 32'h0);
		apb(1'b1, `SHS_A_DMA_COUNT, 32'h5);
		dm.hdr(shs_pkg::SHS_FR_DMA_ACT, 1'b0, 1'b1, 8'h00, 8'h00, 16'h0, 32'h0);
		tick(4);
		check("write held", {31'h0, dma_wr_ready}, 32'h0);
		apb(1'b1, `SHS_A_DMA_CTRL, 32'h1);
		eq.delete();
		for (int i = 0; i < 5; i++) begin
			nr();
			eq.push_back(v);
			dma_wr_valid <= 1'b1;
			dma_wr_data <= v;
			do @(posedge pclk); while (!dma_wr_ready);
		end
		dma_wr_valid <= 1'b0;
		dma_wr_data <= ~v;
		wait_q(5);
		for (int i = 0; i < 5; i++) check("dma out word", dm.txq[i], eq[i]);
		check("dma out last", {31'h0, dm.lastq[4]}, 32'h1);
		check("dma out total", dm.txq.size(), 5);
		// Service reply: drive returns the queue tag with data request set
		apb(1'b1, `SHS_A_CMD, 32'h0000003C);
		nr();
		dm.hdr(shs_pkg::SHS_FR_REG_D2H, 1'b0, 1'b1, 8'h08, 8'h00, 16'h0, v);
		tick(1);
		rd(`SHS_A_TASK, v, "service tag");
		rd(`SHS_A_STATUS, 32'h08, "service drq");
		// Queued read: data backs up until the context is restored
		apb(1'b1, `SHS_A_DMA_CTRL, 32'h0);
		dm.hdr(shs_pkg::SHS_FR_DATA, 1'b0, 1'b1, 8'h00, 8'h00, 16'h0, 32'h0);
		nr();
		fork
			dm.words(20, v);
		join_none
		tick(40);
		check("not steered early", {31'h0, dma_rd_valid}, 32'h0);
		check("throttled", {31'h0, rx_ready}, 32'h0);
		dma_rd_ready <= 1'b1;
		apb(1'b1, `SHS_A_DMA_CTRL, 32'h1);
		for (int i = 0; i < 300 && rq.size() < 20; i++) @(posedge pclk);
		for (int i = 0; i < 20; i++) check("dma in word", rq[i], v + i);
		nr();
		dm.hdr(shs_pkg::SHS_FR_REG_D2H, 1'b1, 1'b1, 8'h50, 8'h00, 16'h0, v);
		tick(2);
		check("completion irq", {31'h0, irq}, 32'h1);
		rd(`SHS_A_TASK, v, "completion task");
		rd(`SHS_A_STATUS, 32'h50, "completion status");
		tick(1);
		check("irq released", {31'h0, irq}, 32'h0);
		stop_test();
	end
endmodule // tb
`default_nettype wire
